//--- design/tecm_error_monitor.sv
// Summary of operation
// R1: Latch counts on one-second, 42ms T1, 62ms E1, or manual trigger.
// R2: Every counter saturates at its maximum; line-code counter tops at 65,535.
// R3: T1 line-code counts BPVs plus 16 or 8 zero runs when selected.
// R4: T1 with B8ZS on: substitution codewords are not counted as violations.
// R5: Line-code counter keeps counting even during loss of sync.
// R6: E1 select bit: 0 counts BPVs, 1 counts CVs; HDB3 codewords excluded.
// R7: E1 BPV is two same-polarity marks; CV is two same-polarity BPVs.
// R8: Software picks BPV for AMI lines and CV for HDB3 lines.
// R9: T1 path counts CRC6 under ESF, Ft under D4, plus Fs if selected.
// R10: T1 path counter inhibited while sync is lost.
// R11: E1 path counter counts CRC4 errors.
// R12: E1 path and E-bit counters stop on FAS/CRC4 loss, not CAS loss.
// R13: Path, frames and E-bit counts are 16 bits, MSW then LSW register.
// R14: T1 out-of-sync option counts multiframes out of sync, even unsynced.
// R15: T1 F-bit option counts Ft (D4) or FPS (ESF), inhibited unsynced.
// R16: E1 frames counter counts FAS errors, inhibited unsynced or searching.
// R17: E-bit counter, E1 with CRC4 only, counts each received zero E-bit.
// R18: Software may use the update timing to read latched counts.
// R19: One tx and one rx channel monitored, each chosen by 5-bit field.
// R20: Software programs select fields as channel number minus one.
// R21: All accumulators latch together on a trigger, then restart cleanly.
`timescale 1ns/10ps
module tecm_error_monitor
  import tecm_pkg::*;
#(
  parameter longint ONE_SEC_CYCLES = ONE_SEC_CYC,
  parameter longint T1_SHORT_CYCLES = T1_SHORT_CYC,
  parameter longint E1_SHORT_CYCLES = E1_SHORT_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive framer side
  input  wire tecm_rx_ev_t rx_ev,
  input  wire tecm_sync_t  sync_st,
  // Channel byte streams
  input  wire tecm_chan_t  tx_chan,
  input  wire tecm_chan_t  rx_chan,
  // Update timing
  output logic             update_pulse
);

  logic [CFG_WIDTH-1:0] error_counter_config;
  logic [4:0]           tx_monitor_channel_field;
  logic [4:0]           rx_monitor_channel_field;
  logic [7:0]           tx_channel_monitor_byte;
  logic [7:0]           rx_channel_monitor_byte;
  logic [15:0]          line_code_violation_count;
  logic [15:0]          path_error_count;
  logic [15:0]          frame_sync_loss_count;
  logic [15:0]          far_end_block_error_count;
  logic [15:0]          acc_lcv;
  logic [15:0]          acc_path;
  logic [15:0]          acc_fos;
  logic [15:0]          acc_ebe;
  logic [31:0]          timer;
  logic                 manual_req;
  logic                 update_seen;
  logic                 last_pol;
  logic                 last_bpv_pol;
  logic                 have_mark;
  logic                 have_bpv;
  logic [4:0]           zero_run;

  logic       is_e1;
  logic       is_esf;
  logic       zsub_on;
  logic       crc4_on;
  tecm_upd_t  upd_sel;
  logic       apb_wr;
  logic       apb_rd;
  logic       trigger;
  logic       timer_done;
  logic       status_rd;
  logic [31:0] period_m1;
  logic       bpv;
  logic       cv;
  logic       exz;
  logic       lcv_ev;
  logic       path_ev;
  logic       fos_ev;
  logic       ebe_ev;
  logic       e1_frame_ok;
  logic [4:0] exz_len;
  logic [31:0] next_prdata;

  assign is_e1   = error_counter_config[CFG_E1_BIT];
  assign is_esf  = error_counter_config[CFG_ESF_BIT];
  assign zsub_on = error_counter_config[CFG_ZSUB_BIT];
  assign crc4_on = error_counter_config[CFG_CRC4_BIT];
  assign upd_sel = tecm_upd_t'(error_counter_config[CFG_UPD_HI:CFG_UPD_LO]);
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign status_rd = psel && penable && !pwrite && paddr == REG_STATUS;

  // Update trigger generation
  always_comb begin
    if (upd_sel == TECM_UPD_SHORT) begin
      period_m1 = is_e1 ? 32'(E1_SHORT_CYCLES - 1) : 32'(T1_SHORT_CYCLES - 1); // R1
    end else begin
      period_m1 = 32'(ONE_SEC_CYCLES - 1);
    end
  end

  // Last cycle of the selected period
  assign timer_done = (timer == period_m1); // R1

  always_comb begin
    case (upd_sel)
      TECM_UPD_ONE_SEC: trigger = timer_done; // R1
      TECM_UPD_SHORT:   trigger = timer_done; // R1
      TECM_UPD_MANUAL:  trigger = manual_req; // R1
      default:          trigger = 1'b0;
    endcase
  end

  // Period timer, held at zero in manual mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= 32'h0000_0000;
    end else if (trigger || timer >= period_m1 || upd_sel == TECM_UPD_MANUAL) begin
      timer <= 32'h0000_0000;
    end else begin
      timer <= timer + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_req <= 1'b0;
    end else begin
      manual_req <= apb_wr && paddr == REG_CONTROL && pwdata[CTL_MANUAL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_pulse <= 1'b0;
    end else begin
      update_pulse <= trigger; // R18
    end
  end

  // Sticky update flag: set wins over read-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_seen <= 1'b0;
    end else if (trigger) begin
      update_seen <= 1'b1;
    end else if (status_rd) begin
      update_seen <= 1'b0;
    end
  end

  // Mark polarity tracking for BPV and CV
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pol     <= 1'b0;
      have_mark    <= 1'b0;
      last_bpv_pol <= 1'b0;
      have_bpv     <= 1'b0;
    end else if (rx_ev.sym_valid && rx_ev.mark) begin
      last_pol  <= rx_ev.polarity;
      have_mark <= 1'b1;
      if (bpv) begin
        last_bpv_pol <= rx_ev.polarity;
        have_bpv     <= 1'b1;
      end
    end
  end

  // Consecutive zero run, restarting after each full run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_run <= 5'h00;
    end else if (rx_ev.sym_valid) begin
      if (rx_ev.mark) begin
        zero_run <= 5'h00;
      end else if (zero_run == exz_len) begin
        zero_run <= 5'h01;
      end else begin
        zero_run <= zero_run + 5'h01;
      end
    end
  end

  // Run length that counts as excessive zeros
  assign exz_len = zsub_on ? EXZ_RUN_ZSUB : EXZ_RUN_PLAIN; // R3
  // Same polarity as previous mark, codewords excluded when decoding
  assign bpv = rx_ev.sym_valid && rx_ev.mark && have_mark && rx_ev.polarity == last_pol
               && !(zsub_on && rx_ev.zsub_codeword); // R4 R6 R7
  assign cv  = bpv && have_bpv && rx_ev.polarity == last_bpv_pol; // R7
  assign exz = rx_ev.sym_valid && !rx_ev.mark && error_counter_config[CFG_EXZ_BIT]
               && zero_run == exz_len - 5'h01; // R3

  always_comb begin
    if (is_e1) begin
      lcv_ev = error_counter_config[CFG_CV_BIT] ? cv : bpv; // R6
    end else begin
      lcv_ev = bpv || exz; // R3
    end
  end

  // CAS multiframe loss leaves these counters running
  assign e1_frame_ok = !sync_st.fas_sync_lost && !sync_st.crc4_sync_lost; // R12

  always_comb begin
    if (is_e1) begin
      path_ev = rx_ev.crc_error && e1_frame_ok; // R11 R12
    end else if (is_esf) begin
      path_ev = rx_ev.crc_error && !sync_st.receive_sync_lost; // R9 R10
    end else begin
      path_ev = (rx_ev.ft_error || (error_counter_config[CFG_FS_BIT] && rx_ev.fs_error))
                && !sync_st.receive_sync_lost; // R9 R10
    end
  end

  always_comb begin
    if (is_e1) begin
      fos_ev = rx_ev.fas_error && !sync_st.receive_sync_lost && !sync_st.searching; // R16
    end else if (!error_counter_config[CFG_FBIT_BIT]) begin
      fos_ev = rx_ev.multiframe_end && sync_st.receive_sync_lost; // R14
    end else begin
      fos_ev = (is_esf ? rx_ev.fps_error : rx_ev.ft_error)
               && !sync_st.receive_sync_lost; // R15
    end
  end

  assign ebe_ev = is_e1 && crc4_on && rx_ev.ebit_valid && !rx_ev.ebit && e1_frame_ok; // R17 R12

  // Accumulators restart on trigger, carrying an event of that cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_lcv  <= 16'h0000;
      acc_path <= 16'h0000;
      acc_fos  <= 16'h0000;
      acc_ebe  <= 16'h0000;
    end else if (trigger) begin
      acc_lcv  <= {15'h0000, lcv_ev}; // R21 R5
      acc_path <= {15'h0000, path_ev}; // R21
      acc_fos  <= {15'h0000, fos_ev}; // R21
      acc_ebe  <= {15'h0000, ebe_ev}; // R21
    end else begin
      acc_lcv  <= tecm_sat_inc(acc_lcv, lcv_ev); // R2 R5
      acc_path <= tecm_sat_inc(acc_path, path_ev); // R2
      acc_fos  <= tecm_sat_inc(acc_fos, fos_ev); // R2
      acc_ebe  <= tecm_sat_inc(acc_ebe, ebe_ev); // R2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_code_violation_count <= 16'h0000;
      path_error_count          <= 16'h0000;
      frame_sync_loss_count     <= 16'h0000;
      far_end_block_error_count <= 16'h0000;
    end else if (trigger) begin
      line_code_violation_count <= acc_lcv; // R21 R1
      path_error_count          <= acc_path; // R21
      frame_sync_loss_count     <= acc_fos; // R21
      far_end_block_error_count <= acc_ebe; // R21
    end
  end

  // Channel monitors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_channel_monitor_byte <= 8'h00;
    end else if (tx_chan.valid && tx_chan.chan == tx_monitor_channel_field) begin
      tx_channel_monitor_byte <= tx_chan.data; // R19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_channel_monitor_byte <= 8'h00;
    end else if (rx_chan.valid && rx_chan.chan == rx_monitor_channel_field) begin
      rx_channel_monitor_byte <= rx_chan.data; // R19
    end
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_counter_config     <= CFG_RESET;
      tx_monitor_channel_field <= 5'h00;
      rx_monitor_channel_field <= 5'h00;
    end else if (apb_wr) begin
      case (paddr)
        REG_CONFIG: error_counter_config     <= pwdata[CFG_WIDTH-1:0];
        REG_TX_SEL: tx_monitor_channel_field <= pwdata[4:0] & CHAN_LAST; // R19
        REG_RX_SEL: rx_monitor_channel_field <= pwdata[4:0] & CHAN_LAST; // R19
        default: ;
      endcase
    end
  end

  // Split a 16-bit count over two byte-wide registers
  function automatic logic [31:0] tecm_hi_byte(input logic [15:0] v);
    tecm_hi_byte = {24'h00_0000, v[15:8]}; // R13
  endfunction : tecm_hi_byte

  function automatic logic [31:0] tecm_lo_byte(input logic [15:0] v);
    tecm_lo_byte = {24'h00_0000, v[7:0]}; // R13
  endfunction : tecm_lo_byte

  // Read mux, captured in setup phase
  always_comb begin
    case (paddr)
      REG_CONFIG:   next_prdata = {22'h00_0000, error_counter_config};
      REG_LCV:      next_prdata = {16'h0000, line_code_violation_count};
      REG_PATH_MSW: next_prdata = tecm_hi_byte(path_error_count); // R13
      REG_PATH_LSW: next_prdata = tecm_lo_byte(path_error_count); // R13
      REG_FOS_MSW:  next_prdata = tecm_hi_byte(frame_sync_loss_count); // R13
      REG_FOS_LSW:  next_prdata = tecm_lo_byte(frame_sync_loss_count); // R13
      REG_EBE_MSW:  next_prdata = tecm_hi_byte(far_end_block_error_count); // R13
      REG_EBE_LSW:  next_prdata = tecm_lo_byte(far_end_block_error_count); // R13
      REG_TX_SEL:   next_prdata = {27'h000_0000, tx_monitor_channel_field};
      REG_RX_SEL:   next_prdata = {27'h000_0000, rx_monitor_channel_field};
      REG_TX_MON:   next_prdata = {24'h00_0000, tx_channel_monitor_byte};
      REG_RX_MON:   next_prdata = {24'h00_0000, rx_channel_monitor_byte};
      REG_STATUS:   next_prdata = {31'h0000_0000, update_seen};
      default:      next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      prdata <= next_prdata;
    end
  end

endmodule : tecm_error_monitor

//--- design/tecm_pkg.sv
package tecm_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CONFIG   = 8'h00;
  localparam logic [7:0] REG_CONTROL  = 8'h04;
  localparam logic [7:0] REG_LCV      = 8'h08;
  localparam logic [7:0] REG_PATH_MSW = 8'h0C;
  localparam logic [7:0] REG_PATH_LSW = 8'h10;
  localparam logic [7:0] REG_FOS_MSW  = 8'h14;
  localparam logic [7:0] REG_FOS_LSW  = 8'h18;
  localparam logic [7:0] REG_EBE_MSW  = 8'h1C;
  localparam logic [7:0] REG_EBE_LSW  = 8'h20;
  localparam logic [7:0] REG_TX_SEL   = 8'h24;
  localparam logic [7:0] REG_RX_SEL   = 8'h28;
  localparam logic [7:0] REG_TX_MON   = 8'h2C;
  localparam logic [7:0] REG_RX_MON   = 8'h30;
  localparam logic [7:0] REG_STATUS   = 8'h34;

  // Configuration field positions
  localparam int CFG_EXZ_BIT    = 0;
  localparam int CFG_FBIT_BIT   = 1;
  localparam int CFG_FS_BIT     = 2;
  localparam int CFG_CV_BIT     = 3;
  localparam int CFG_UPD_LO     = 4;
  localparam int CFG_UPD_HI     = 5;
  localparam int CFG_E1_BIT     = 6;
  localparam int CFG_ESF_BIT    = 7;
  localparam int CFG_ZSUB_BIT   = 8;
  localparam int CFG_CRC4_BIT   = 9;
  localparam int CFG_WIDTH      = 10;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 10'h000;

  localparam int CTL_MANUAL_BIT = 0;
  localparam int STS_UPDATE_BIT = 0;

  // Update trigger selection
  typedef enum logic [1:0] {
    TECM_UPD_ONE_SEC = 2'b00,
    TECM_UPD_SHORT   = 2'b01,
    TECM_UPD_MANUAL  = 2'b10,
    TECM_UPD_NONE    = 2'b11
  } tecm_upd_t;

  // Timing: 1 s, 42 ms, 62 ms at the bus clock rate
  localparam longint CLK_HZ        = 40_000_000;
  localparam longint ONE_SEC_MS    = 1000;
  localparam longint T1_SHORT_MS   = 42;
  localparam longint E1_SHORT_MS   = 62;
  localparam longint ONE_SEC_CYC   = CLK_HZ * ONE_SEC_MS / 1000;
  localparam longint T1_SHORT_CYC  = CLK_HZ * T1_SHORT_MS / 1000;
  localparam longint E1_SHORT_CYC  = CLK_HZ * E1_SHORT_MS / 1000;

  // Run-length thresholds for excessive zeros
  localparam logic [4:0] EXZ_RUN_PLAIN = 5'h10;
  localparam logic [4:0] EXZ_RUN_ZSUB  = 5'h08;

  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [4:0]  CHAN_LAST = 5'h1F;

  // Receive line symbol and framer event bundle
  typedef struct packed {
    logic       sym_valid;
    logic       mark;
    logic       polarity;
    logic       zsub_codeword;
    logic       crc_error;
    logic       ft_error;
    logic       fs_error;
    logic       fps_error;
    logic       fas_error;
    logic       multiframe_end;
    logic       ebit_valid;
    logic       ebit;
  } tecm_rx_ev_t;

  // Framer sync state bundle
  typedef struct packed {
    logic receive_sync_lost;
    logic fas_sync_lost;
    logic crc4_sync_lost;
    logic cas_sync_lost;
    logic searching;
  } tecm_sync_t;

  // Channel byte strobe bundle
  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
    logic [7:0] data;
  } tecm_chan_t;

  function automatic logic [15:0] tecm_sat_inc(input logic [15:0] v, input logic inc);
    tecm_sat_inc = (inc && v != CNT_MAX) ? v + 16'h0001 : v;
  endfunction : tecm_sat_inc

endpackage : tecm_pkg

//--- dv/tecm_error_monitor_asserts.sv
`timescale 1ns/10ps
module tecm_error_monitor_chk
  import tecm_pkg::*;
#(
  parameter longint ONE_SEC_CYCLES  = ONE_SEC_CYC,
  parameter longint T1_SHORT_CYCLES = T1_SHORT_CYC,
  parameter longint E1_SHORT_CYCLES = E1_SHORT_CYC
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus and update
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        update_pulse
);
  logic [1:0]  cfg_upd;
  logic        cfg_e1;
  logic        per_ok;
  logic [31:0] gap;
  wire         wr     = psel && penable && pwrite && pready;
  wire         man_wr = wr && paddr == REG_CONTROL && pwdata[CTL_MANUAL_BIT] && cfg_upd == 2'b10;
  wire         rd_set = psel && !penable && !pwrite;
  wire  [31:0] per    = cfg_upd == 2'b00 ? 32'(ONE_SEC_CYCLES) :
                        cfg_e1 ? 32'(E1_SHORT_CYCLES) : 32'(T1_SHORT_CYCLES);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Shadow of the update selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_upd <= 2'b00;
      cfg_e1  <= 1'b0;
    end else if (wr && paddr == REG_CONFIG) begin
      cfg_upd <= pwdata[CFG_UPD_HI:CFG_UPD_LO];
      cfg_e1  <= pwdata[CFG_E1_BIT];
    end
  end

  // Cycles since last pulse; valid only without writes in between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap    <= 32'h0000_0000;
      per_ok <= 1'b0;
    end else begin
      gap    <= update_pulse ? 32'h0000_0000 : gap + 32'h0000_0001;
      per_ok <= wr ? 1'b0 : (update_pulse ? 1'b1 : per_ok);
    end
  end

  AST_MANUAL_LATCH: assert property (man_wr |-> ##2 update_pulse)
    else $error("manual request gave no update pulse");
  AST_MANUAL_ONLY: assert property (update_pulse && cfg_upd == 2'b10 &&
    $past(cfg_upd, 2) == 2'b10 |-> $past(man_wr, 2))
    else $error("update pulse in manual mode without request");
  AST_PERIOD: assert property (update_pulse && per_ok && !cfg_upd[1] |-> gap == per - 1)
    else $error("update period wrong");
  AST_NO_UPDATE: assert property (cfg_upd == 2'b11 && $past(cfg_upd) == 2'b11 &&
    $past(cfg_upd, 2) == 2'b11 |-> !update_pulse)
    else $error("update pulse with updates off");
  AST_PULSE_ONE: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse longer than one cycle");
  AST_LCV_16: assert property (rd_set && paddr == REG_LCV |=> prdata[31:16] == 16'h0000)
    else $error("line code count wider than 16 bits");
  AST_HALF_WORD: assert property (rd_set && paddr >= REG_PATH_MSW && paddr <= REG_EBE_LSW
    |=> prdata[31:8] == 24'h00_0000)
    else $error("count half register wider than 8 bits");
  AST_SEL_5BIT: assert property (rd_set && (paddr == REG_TX_SEL || paddr == REG_RX_SEL)
    |=> prdata[31:5] == 27'h000_0000)
    else $error("channel select wider than 5 bits");
endmodule : tecm_error_monitor_chk

bind tecm_error_monitor tecm_error_monitor_chk #(
  .ONE_SEC_CYCLES(ONE_SEC_CYCLES),
  .T1_SHORT_CYCLES(T1_SHORT_CYCLES),
  .E1_SHORT_CYCLES(E1_SHORT_CYCLES)
) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .update_pulse(update_pulse));

//--- dv/tecm_framer_model.sv
`timescale 1ns/10ps
module tecm_framer_model
  import tecm_pkg::*;
(
  // Clock
  input wire logic  pclk,
  // Framer outputs
  output tecm_rx_ev_t rx_ev,
  output tecm_sync_t  sync_st,
  output tecm_chan_t  tx_chan,
  output tecm_chan_t  rx_chan
);
  initial begin
    rx_ev   = '0;
    sync_st = '0;
    tx_chan = '0;
    rx_chan = '0;
  end

  // Same event held for n cycles counts n times
  task automatic run(input tecm_rx_ev_t e, input int n);
    @(posedge pclk);
    rx_ev <= e;
    repeat (n) @(posedge pclk);
    rx_ev <= '0;
  endtask : run

  task automatic set_sync(input tecm_sync_t s);
    @(posedge pclk);
    sync_st <= s;
  endtask : set_sync

  // Released byte lanes show inverted data
  task automatic chan(input logic [4:0] c, input logic [7:0] dt, input logic [7:0] dr);
    @(posedge pclk);
    tx_chan <= '{1'b1, c, dt};
    rx_chan <= '{1'b1, c, dr};
    @(posedge pclk);
    tx_chan <= '{1'b0, ~c, ~dt};
    rx_chan <= '{1'b0, ~c, ~dr};
  endtask : chan
endmodule : tecm_framer_model

//--- dv/tecm_error_monitor_tb.sv
`timescale 1ns/10ps
module tecm_error_monitor_tb;
  import tecm_pkg::*;
  typedef struct packed {
    logic [9:0]  cfg;
    tecm_rx_ev_t ev;
    tecm_sync_t  sy;
    logic [7:0]  a;
    logic        c;
  } tecm_case_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, update_pulse;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, etx, erx;
  tecm_rx_ev_t rx_ev;
  tecm_sync_t  sync_st;
  tecm_chan_t  tx_chan, rx_chan;
  int          error_cnt, tests_run, n, g;
  logic [31:0] exp_q[$];
  tecm_case_t  cases[20] = '{
    '{10'h0A0, 12'h080, 5'h00, REG_PATH_LSW, 1'b1}, '{10'h020, 12'h040, 5'h00, REG_PATH_LSW, 1'b1},
    '{10'h024, 12'h020, 5'h00, REG_PATH_LSW, 1'b1}, '{10'h020, 12'h020, 5'h00, REG_PATH_LSW, 1'b0},
    '{10'h0A0, 12'h080, 5'h10, REG_PATH_LSW, 1'b0}, '{10'h020, 12'h004, 5'h10, REG_FOS_LSW, 1'b1},
    '{10'h020, 12'h004, 5'h00, REG_FOS_LSW, 1'b0}, '{10'h022, 12'h040, 5'h00, REG_FOS_LSW, 1'b1},
    '{10'h0A2, 12'h010, 5'h00, REG_FOS_LSW, 1'b1}, '{10'h022, 12'h040, 5'h10, REG_FOS_LSW, 1'b0},
    '{10'h060, 12'h080, 5'h02, REG_PATH_LSW, 1'b1}, '{10'h060, 12'h080, 5'h08, REG_PATH_LSW, 1'b0},
    '{10'h060, 12'h080, 5'h04, REG_PATH_LSW, 1'b0}, '{10'h060, 12'h008, 5'h00, REG_FOS_LSW, 1'b1},
    '{10'h060, 12'h008, 5'h01, REG_FOS_LSW, 1'b0}, '{10'h260, 12'h002, 5'h00, REG_EBE_LSW, 1'b1},
    '{10'h260, 12'h003, 5'h00, REG_EBE_LSW, 1'b0}, '{10'h060, 12'h002, 5'h00, REG_EBE_LSW, 1'b0},
    '{10'h260, 12'h002, 5'h08, REG_EBE_LSW, 1'b0}, '{10'h260, 12'h002, 5'h02, REG_EBE_LSW, 1'b1}};
  logic [9:0]  tcfg[4] = '{10'h000, 10'h010, 10'h050, 10'h030};
  int          tper[4] = '{100, 20, 30, 250};

  tecm_error_monitor #(.ONE_SEC_CYCLES(100), .T1_SHORT_CYCLES(20), .E1_SHORT_CYCLES(30))
    tecm_error_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_ev(rx_ev), .sync_st(sync_st), .tx_chan(tx_chan),
    .rx_chan(rx_chan), .update_pulse(update_pulse));
  tecm_framer_model tecm_framer_model_i (.pclk(pclk), .rx_ev(rx_ev), .sync_st(sync_st),
    .tx_chan(tx_chan), .rx_chan(rx_chan));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      error_cnt++;
      finish_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic trig();
    apb(1'b1, REG_CONTROL, 32'h0000_0001);
  endtask : trig

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // Known line state (last mark and last violation positive), then clear
  task automatic prep(input logic [9:0] cfg, input tecm_sync_t s);
    tecm_framer_model_i.set_sync(s);
    apb(1'b1, REG_CONFIG, {22'h0, cfg});
    tecm_framer_model_i.run(12'hE00, 2);
    trig();
  endtask : prep

  task automatic wait_pulse(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (update_pulse !== 1'b1 && c < 250);
  endtask : wait_pulse

  // Result watcher
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      check({31'h0000_0000, pslverr}, 32'h0000_0000);
    end
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      check(prdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    void'($urandom(78864));
    do_reset();
    rd(REG_CONFIG, 32'h0000_0000);
    rd(REG_LCV, 32'h0000_0000);
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0000_0000);
    n = $urandom_range(20, 1);
    prep(10'h020, 5'h10);
    tecm_framer_model_i.run(12'hE00, n);
    trig();
    rd(REG_STATUS, 32'h0000_0001);
    rd(REG_STATUS, 32'h0000_0000);
    rd(REG_LCV, n);
    prep(10'h021, 5'h00);
    tecm_framer_model_i.run(12'h800, 31);
    trig();
    rd(REG_LCV, 32'h0000_0001);
    prep(10'h121, 5'h00);
    tecm_framer_model_i.run(12'h800, 15);
    tecm_framer_model_i.run(12'hF00, 3);
    trig();
    rd(REG_LCV, 32'h0000_0001);
    for (int cv = 0; cv < 2; cv++) begin
      prep(10'h060 | 10'(cv << 3), 5'h08);
      for (int j = 0; j < 8; j++) begin
        tecm_framer_model_i.run({2'b11, 1'(8'hE6 >> j), 9'h000}, 1);
      end
      trig();
      rd(REG_LCV, cv ? 32'h0000_0002 : 32'h0000_0004);
    end
    prep(10'h168, 5'h00);
    tecm_framer_model_i.run(12'hF00, 2);
    trig();
    rd(REG_LCV, 32'h0000_0000);
    foreach (cases[i]) begin
      n = $urandom_range(12, 1);
      prep(cases[i].cfg, cases[i].sy);
      tecm_framer_model_i.run(cases[i].ev, n);
      trig();
      rd(cases[i].a - 8'h04, 32'h0000_0000);
      rd(cases[i].a, cases[i].c ? n : 0);
    end
    trig();
    rd(REG_EBE_LSW, 32'h0000_0000);
    prep(10'h020, 5'h00);
    tecm_framer_model_i.run(12'hE00, 65537);
    trig();
    rd(REG_LCV, 32'h0000_FFFF);
    apb(1'b1, REG_TX_SEL, 32'h0000_0005);
    apb(1'b1, REG_RX_SEL, 32'h0000_000E);
    for (int c = 0; c < 32; c++) begin
      etx[7:0] = (c == 5) ? 8'($urandom) : etx[7:0];
      erx[7:0] = (c == 14) ? 8'($urandom) : erx[7:0];
      tecm_framer_model_i.chan(5'(c), c == 5 ? etx[7:0] : 8'($urandom),
                               c == 14 ? erx[7:0] : 8'($urandom));
    end
    rd(REG_TX_SEL, 32'h0000_0005);
    rd(REG_RX_SEL, 32'h0000_000E);
    rd(REG_TX_MON, {24'h0, etx[7:0]});
    rd(REG_RX_MON, {24'h0, erx[7:0]});
    for (int m = 0; m < 4; m++) begin
      do_reset();
      apb(1'b1, REG_CONFIG, {22'h0, tcfg[m]});
      wait_pulse(g);
      wait_pulse(g);
      check(g, tper[m]);
    end
    finish_test();
  end
endmodule : tecm_error_monitor_tb
